// ### rus_streamer.sv
`timescale 1ns/10ps
`include "rus_regs.svh"
module rus_streamer
    import rus_pkg::*;
#(
    parameter int FS_FRAC = 24
)
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [31:0] cmd_src_ip,
    input  wire logic [31:0] tc_rate_hz,
    input  wire logic [31:0] sync_rate_hz,
    input  wire logic        sync_filt_on,
    input  wire logic [31:0] meas_flt [4],
    input  wire logic [31:0] meas_fix [4],
    output logic             udp_valid,
    input  wire logic        udp_ready,
    output logic      [7:0]  udp_data,
    output logic             udp_last,
    output logic      [15:0] udp_dst_port,
    output logic      [31:0] udp_dst_ip,
    output logic      [10:0] udp_len
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    function automatic logic [10:0] rus_pkt_bytes(input logic [1:0] sel);
        return `RUS_PKT_MAX >> sel;
    endfunction : rus_pkt_bytes

    function automatic logic [4:0] rus_set_bytes(input logic [1:0] ch, input logic fmt);
        logic [4:0] nch;
        nch = (ch == 2'h0) ? 5'h01 : (ch == 2'h3) ? 5'h04 : 5'h02;
        return fmt ? 5'(nch << 1) : 5'(nch << 2);
    endfunction : rus_set_bytes

    function automatic logic [`RUS_DIV_W-1:0] rus_mask(input logic [4:0] n);
        return `RUS_DIV_W'((`RUS_DIV_W'(1) << n) - `RUS_DIV_W'(1));
    endfunction : rus_mask

    // software settings and the copy in use while running
    logic [1:0]  ch_reg, ch_next, act_ch_reg, act_ch_next;
    logic [4:0]  rate_reg, rate_next, act_rate_reg, act_rate_next;
    logic        fmt_reg, fmt_next, act_fmt_reg, act_fmt_next;
    logic [1:0]  psize_reg, psize_next, act_psize_reg, act_psize_next;
    logic [15:0] port_reg, port_next;
    logic [1:0]  opt_reg, opt_next, act_opt_reg, act_opt_next;
    logic        run_reg, run_next;
    logic [31:0] rdata_next, ip_next;
    logic [15:0] dport_next;
    logic [10:0] len_next;
    // emitter state
    rus_state_e  state_reg, state_next;
    logic [1:0]  hidx_reg, hidx_next;
    logic [10:0] pleft_reg, pleft_next;
    logic [127:0] setv_reg, setv_next, pendv_reg, pendv_next;
    logic [4:0]  sleft_reg, sleft_next;
    logic        pend_reg, pend_next;
    logic [15:0] seq_reg, seq_next, drop_reg, drop_next;
    // rate generator
    logic [24:0] acc_reg, acc_next;
    logic [`RUS_DIV_W-1:0] div_reg, div_next;
    logic [31:0] max_rate;
    logic [25:0] acc_sum;
    logic        max_tick, sample_tick, start_ok, load;
    logic        push, push_last, buf_in_ready;
    logic [7:0]  push_byte;
    logic [31:0] enc_word [4];
    logic [127:0] built;
    logic [31:0] hdr_word;
    logic [8:0]  buf_out;

    // maximum rate from filter timing
    always_comb
    begin
        max_rate = tc_rate_hz;
        if (sync_filt_on && (sync_rate_hz < max_rate))
            max_rate = sync_rate_hz;
        if (max_rate > `RUS_RATE_CAP)
            max_rate = `RUS_RATE_CAP;
    end

    // register writes, start/stop, read mux
    always_comb
    begin
        ch_next = ch_reg; rate_next = rate_reg; fmt_next = fmt_reg;
        psize_next = psize_reg; port_next = port_reg; opt_next = opt_reg;
        act_ch_next = act_ch_reg; act_rate_next = act_rate_reg; act_fmt_next = act_fmt_reg;
        act_psize_next = act_psize_reg; act_opt_next = act_opt_reg;
        run_next = run_reg;
        dport_next = udp_dst_port;
        ip_next = udp_dst_ip;
        len_next = udp_len;
        start_ok = reg_wr && (reg_addr == `RUS_A_CTRL) && reg_wdata[0] && !run_reg && (state_reg == RUS_IDLE);
        if (reg_wr)
        begin
            case (reg_addr)
                `RUS_A_CTRL:  if (!reg_wdata[0]) run_next = 1'b0;
                `RUS_A_CHAN:  ch_next = reg_wdata[1:0];
                `RUS_A_RATE:  if (reg_wdata <= 32'(`RUS_DIV_MAX)) rate_next = reg_wdata[4:0];
                `RUS_A_FMT:   fmt_next = reg_wdata[0];
                `RUS_A_PSIZE: psize_next = reg_wdata[1:0];
                `RUS_A_PORT:  if (reg_wdata[31:16] == 16'h0000 && reg_wdata[15:0] >= `RUS_PORT_MIN)
                                  port_next = reg_wdata[15:0];
                `RUS_A_OPT:   opt_next = reg_wdata[1:0];
                default:      ;
            endcase
        end
        // settings are copied only at start
        if (start_ok)
        begin
            run_next = 1'b1;
            act_ch_next = ch_reg; act_rate_next = rate_reg; act_fmt_next = fmt_reg;
            act_psize_next = psize_reg; act_opt_next = opt_reg;
            dport_next = port_reg;
            ip_next = cmd_src_ip;
            len_next = 11'(rus_pkt_bytes(psize_reg) + `RUS_HDR_BYTES);
        end
        rdata_next = 32'h0000_0000;
        if (reg_rd)
        begin
            case (reg_addr)
                `RUS_A_CTRL:    rdata_next = {31'h0, run_reg};
                `RUS_A_CHAN:    rdata_next = {30'h0, ch_reg};
                `RUS_A_RATE:    rdata_next = {27'h0, rate_reg};
                `RUS_A_FMT:     rdata_next = {31'h0, fmt_reg};
                `RUS_A_PSIZE:   rdata_next = {30'h0, psize_reg};
                `RUS_A_PORT:    rdata_next = {16'h0, port_reg};
                `RUS_A_OPT:     rdata_next = {30'h0, opt_reg};
                `RUS_A_MAXRATE: rdata_next = max_rate;
                `RUS_A_STATUS:  rdata_next = {drop_reg, 13'h0, pend_reg, state_reg != RUS_IDLE, run_reg};
                `RUS_A_DSTIP:   rdata_next = udp_dst_ip;
                default:        rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ch_reg <= 2'h0; rate_reg <= 5'h00; fmt_reg <= 1'b0; psize_reg <= 2'h0;
            port_reg <= `RUS_PORT_DEF; opt_reg <= `RUS_OPT_DEF;
            act_ch_reg <= 2'h0; act_rate_reg <= 5'h00; act_fmt_reg <= 1'b0;
            act_psize_reg <= 2'h0; act_opt_reg <= `RUS_OPT_DEF;
            run_reg <= 1'b0; reg_rdata <= 32'h0000_0000;
            udp_dst_port <= `RUS_PORT_DEF; udp_dst_ip <= 32'h0000_0000;
            udp_len <= 11'(`RUS_PKT_MAX + `RUS_HDR_BYTES);
        end
        else
        begin
            ch_reg <= ch_next; rate_reg <= rate_next; fmt_reg <= fmt_next; psize_reg <= psize_next;
            port_reg <= port_next; opt_reg <= opt_next;
            act_ch_reg <= act_ch_next; act_rate_reg <= act_rate_next; act_fmt_reg <= act_fmt_next;
            act_psize_reg <= act_psize_next; act_opt_reg <= act_opt_next;
            run_reg <= run_next; reg_rdata <= rdata_next;
            udp_dst_port <= dport_next; udp_dst_ip <= ip_next; udp_len <= len_next;
        end
    end

    // max-rate phase accumulator and power-of-two divider
    always_comb
    begin
        acc_sum  = {1'b0, acc_reg} + 26'(max_rate[20:0]);
        max_tick = run_reg && (acc_sum >= `RUS_CLK_HZ);
        acc_next = max_tick ? 25'(acc_sum - `RUS_CLK_HZ) : acc_sum[24:0];
        div_next = max_tick ? `RUS_DIV_W'(div_reg + `RUS_DIV_W'(1)) : div_reg;
        if (!run_reg)
        begin
            acc_next = 25'h0;
            div_next = '0;
        end
        sample_tick = max_tick && ((div_reg & rus_mask(act_rate_reg)) == '0);
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acc_reg <= 25'h0;
            div_reg <= '0;
        end
        else
        begin
            acc_reg <= acc_next;
            div_reg <= div_next;
        end
    end

    // per-parameter word encoders, all fed from the same instant
    for (genvar p = 0; p < 4; p++)
    begin : g_enc
        rus_word_enc #(.FS_FRAC(FS_FRAC)) u_enc (
            .fmt_int  (act_fmt_reg),
            .little   (act_opt_reg[0]),
            .flt      (meas_flt[p]),
            .fix      (meas_fix[p]),
            .word_out (enc_word[p])
        );
    end

    // pack one sample set, first byte on top
    always_comb
    begin
        built = '0;
        for (int k = 0; k < 4; k++)
        begin
            if (k < ((act_ch_reg == 2'h0) ? 1 : (act_ch_reg == 2'h3) ? 4 : 2))
            begin
                if (act_fmt_reg)
                    built[127 - k*16 -: 16] = enc_word[(act_ch_reg == 2'h2) ? k + 2 : k][31:16];
                else
                    built[127 - k*32 -: 32] = enc_word[(act_ch_reg == 2'h2) ? k + 2 : k];
            end
        end
        hdr_word = {act_ch_reg, act_fmt_reg, act_opt_reg, act_psize_reg, 1'b0,
                    3'h0, act_rate_reg, act_opt_reg[1] ? seq_reg : 16'h0000};
    end

    // packet emitter
    always_comb
    begin
        state_next = state_reg; hidx_next = hidx_reg; pleft_next = pleft_reg;
        setv_next = setv_reg; sleft_next = sleft_reg; pend_next = pend_reg;
        pendv_next = pendv_reg; seq_next = seq_reg; drop_next = drop_reg;
        push = 1'b0; push_byte = 8'h00; push_last = 1'b0;
        load = (sleft_reg == 5'h00) && pend_reg;
        if (load)
        begin
            setv_next  = pendv_reg;
            sleft_next = rus_set_bytes(act_ch_reg, act_fmt_reg);
            pend_next  = 1'b0;
        end
        case (state_reg)
            RUS_IDLE:
            begin
                if (run_reg && (pend_reg || sleft_reg != 5'h00))
                begin
                    state_next = RUS_HDR;
                    hidx_next  = 2'h0;
                end
            end
            RUS_HDR:
            begin
                push = 1'b1;
                push_byte = hdr_word[{~hidx_reg, 3'h0} +: 8];
                if (buf_in_ready)
                begin
                    hidx_next = 2'(hidx_reg + 2'h1);
                    if (hidx_reg == `RUS_HDR_LAST)
                    begin
                        state_next = RUS_DATA;
                        pleft_next = rus_pkt_bytes(act_psize_reg);
                    end
                end
            end
            RUS_DATA:
            begin
                if (sleft_reg != 5'h00 || !run_reg)
                begin
                    push = 1'b1;
                    push_byte = (sleft_reg != 5'h00) ? setv_reg[127:120] : 8'h00;
                    push_last = (pleft_reg == 11'h001);
                    if (buf_in_ready)
                    begin
                        if (sleft_reg != 5'h00)
                        begin
                            setv_next  = {setv_reg[119:0], 8'h00};
                            sleft_next = 5'(sleft_reg - 5'h01);
                        end
                        pleft_next = 11'(pleft_reg - 11'h001);
                        if (pleft_reg == 11'h001)
                        begin
                            state_next = RUS_IDLE;
                            seq_next   = 16'(seq_reg + 16'h0001);
                        end
                    end
                end
            end
            default: state_next = RUS_IDLE;
        endcase
        // new sample set; a set still waiting is overwritten never, the new one is dropped
        if (sample_tick)
        begin
            if (pend_reg && !load)
                drop_next = 16'(drop_reg + 16'h0001);
            else
            begin
                pend_next  = 1'b1;
                pendv_next = built;
            end
        end
        if (start_ok)
        begin
            pend_next  = 1'b0;
            sleft_next = 5'h00;
            seq_next   = 16'h0000;
            drop_next  = 16'h0000;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= RUS_IDLE; hidx_reg <= 2'h0; pleft_reg <= 11'h000;
            setv_reg <= '0; sleft_reg <= 5'h00; pend_reg <= 1'b0; pendv_reg <= '0;
            seq_reg <= 16'h0000; drop_reg <= 16'h0000;
        end
        else
        begin
            state_reg <= state_next; hidx_reg <= hidx_next; pleft_reg <= pleft_next;
            setv_reg <= setv_next; sleft_reg <= sleft_next; pend_reg <= pend_next; pendv_reg <= pendv_next;
            seq_reg <= seq_next; drop_reg <= drop_next;
        end
    end

    // two-entry output buffer absorbs receiver stalls
    rus_buf2 #(.W(9)) u_buf (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .in_valid  (push),
        .in_ready  (buf_in_ready),
        .in_data   ({push_last, push_byte}),
        .out_valid (udp_valid),
        .out_ready (udp_ready),
        .out_data  (buf_out)
    );
    assign udp_data = buf_out[7:0];
    assign udp_last = buf_out[8];

    sequence s_pkt_start;
        state_reg == RUS_IDLE ##1 state_reg == RUS_HDR;
    endsequence

    sequence s_hdr_done;
        state_reg == RUS_HDR && hidx_reg == `RUS_HDR_LAST && buf_in_ready;
    endsequence

    AST_RATE_RANGE: assert property (rate_reg <= `RUS_DIV_MAX)
        else $error("rate divider above limit");
    AST_PORT_RANGE: assert property (port_reg >= `RUS_PORT_MIN)
        else $error("destination port below limit");
    AST_MAX_CAP: assert property (reg_rd && reg_addr == `RUS_A_MAXRATE |=> reg_rdata <= `RUS_RATE_CAP)
        else $error("max rate read above cap");
    AST_RATE_READ: assert property (reg_rd && reg_addr == `RUS_A_RATE |=> reg_rdata == {27'h0, $past(rate_reg)})
        else $error("divider read does not return n");
    AST_HOLD_CFG: assert property (run_reg && $past(run_reg) |-> $stable(act_fmt_reg) && $stable(act_ch_reg)
        && $stable(udp_dst_port))
        else $error("settings changed while streaming");
    AST_PKT_LEN: assert property (run_reg |-> udp_len == rus_pkt_bytes(act_psize_reg) + `RUS_HDR_BYTES)
        else $error("payload length mismatch");
    AST_HDR_FIRST: assert property (s_pkt_start |-> hidx_reg == 2'h0 && push)
        else $error("header does not open packet");
    AST_DATA_LEN: assert property (s_hdr_done |=> state_reg == RUS_DATA && pleft_reg == rus_pkt_bytes(act_psize_reg))
        else $error("data byte count wrong");
    AST_FULL_RATE: assert property (run_reg && act_rate_reg == 5'h00 && max_tick |-> sample_tick)
        else $error("n of zero skipped a sample");
    AST_STOP: assert property (reg_wr && reg_addr == `RUS_A_CTRL && !reg_wdata[0] |=> !run_reg)
        else $error("stream did not stop");
endmodule : rus_streamer

// ### rus_regs.svh
`ifndef RUS_REGS_SVH
`define RUS_REGS_SVH

// register offsets
`define RUS_A_CTRL    8'h00
`define RUS_A_CHAN    8'h04
`define RUS_A_RATE    8'h08
`define RUS_A_FMT     8'h0C
`define RUS_A_PSIZE   8'h10
`define RUS_A_PORT    8'h14
`define RUS_A_OPT     8'h18
`define RUS_A_MAXRATE 8'h1C
`define RUS_A_STATUS  8'h20
`define RUS_A_DSTIP   8'h24

// reset values and limits
`define RUS_PORT_DEF  16'h0749
`define RUS_PORT_MIN  16'h0400
`define RUS_OPT_DEF   2'h2
`define RUS_DIV_MAX   5'h14
`define RUS_DIV_W     21
`define RUS_RATE_CAP  32'h001312D0
`define RUS_CLK_HZ    26'h1312D00
`define RUS_PKT_MAX   11'h400
`define RUS_HDR_BYTES 11'h004
`define RUS_HDR_LAST  2'h3

// int16 scaling
`define RUS_FS_CODE   17'h07333
`define RUS_INT_MAX   16'h7FFF
`define RUS_INT_MIN   16'h8000

`endif

// ### rus_pkg.sv
package rus_pkg;
    typedef enum logic [1:0] {RUS_IDLE, RUS_HDR, RUS_DATA} rus_state_e;
    typedef logic [7:0] rus_byte_t;
endpackage : rus_pkg

// ### rus_word_enc.sv
`timescale 1ns/10ps
`include "rus_regs.svh"
module rus_word_enc
    import rus_pkg::*;
#(
    parameter int FS_FRAC = 24
)
(
    input  wire logic        fmt_int,
    input  wire logic        little,
    input  wire logic [31:0] flt,
    input  wire logic [31:0] fix,
    output logic      [31:0] word_out
);
    logic signed [48:0] prod;
    logic signed [48:0] scaled;
    logic        [15:0] code;

    // scale to full-scale code, saturate at the int16 limits
    always_comb
    begin
        prod   = 49'($signed(fix)) * 49'($signed({1'b0, `RUS_FS_CODE}));
        scaled = prod >>> FS_FRAC;
        if (scaled[48:15] == {34{scaled[15]}})
            code = scaled[15:0];
        else
            code = scaled[48] ? `RUS_INT_MIN : `RUS_INT_MAX;
    end

    // bytes in send order, first byte in the top lane
    always_comb
    begin
        if (fmt_int)
            word_out = little ? {code[7:0], code[15:8], 16'h0000} : {code, 16'h0000};
        else
            word_out = little ? {flt[7:0], flt[15:8], flt[23:16], flt[31:24]} : flt;
    end
endmodule : rus_word_enc

// ### rus_buf2.sv
`timescale 1ns/10ps
module rus_buf2
    import rus_pkg::*;
#(
    parameter int W = 9
)
(
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    logic [W-1:0] mem_reg [2];
    logic [W-1:0] mem_next [2];
    logic         wp_reg, wp_next, rp_reg, rp_next;
    logic [1:0]   cnt_reg, cnt_next;

    assign in_ready  = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data  = mem_reg[rp_reg];

    // pointer and count update
    always_comb
    begin
        mem_next = mem_reg;
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        cnt_next = cnt_reg;
        if (in_valid && in_ready)
        begin
            mem_next[wp_reg] = in_data;
            wp_next          = ~wp_reg;
        end
        if (out_valid && out_ready)
            rp_next = ~rp_reg;
        cnt_next = 2'(cnt_reg + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready});
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wp_reg     <= 1'b0;
            rp_reg     <= 1'b0;
            cnt_reg    <= 2'h0;
        end
        else
        begin
            mem_reg <= mem_next;
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    AST_BUF_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffer lost a stalled word");
endmodule : rus_buf2

// ### rus_rx_model.sv
`timescale 1ns/10ps
module rus_rx_model
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       slow,
    input  wire logic       udp_valid,
    input  wire logic [7:0] udp_data,
    input  wire logic       udp_last,
    output logic            udp_ready
);
    logic [7:0] q [$];
    int         len_q [$];
    int         cnt;
    int         ph;

    // takes bytes, stalls two of three cycles when slow
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            udp_ready <= 1'b0;
            cnt       <= 0;
            ph        <= 0;
        end
        else
        begin
            ph        <= ph + 1;
            udp_ready <= !slow || (ph % 3 == 0);
            if (udp_valid && udp_ready)
            begin
                q.push_back(udp_data);
                cnt <= udp_last ? 0 : cnt + 1;
                if (udp_last)
                    len_q.push_back(cnt + 1);
            end
        end
    end
endmodule : rus_rx_model

// ### realtime_udp_sample_streamer_test.sv
`timescale 1ns/10ps
`include "rus_regs.svh"
module realtime_udp_sample_streamer_test import rus_pkg::*;;
    typedef struct packed {logic [1:0] ch; logic fmt; logic [1:0] opt, ps; logic [10:0] len; logic [31:0] w;} rus_row_s;

    logic        ref_clk      = 1'b0;
    logic        rstn         = 1'b0;
    logic [7:0]  reg_addr     = 8'h00;
    logic [31:0] reg_wdata    = 32'h0;
    logic        reg_wr       = 1'b0;
    logic        reg_rd       = 1'b0;
    logic [31:0] cmd_src_ip   = 32'hC0A80017;
    logic [31:0] tc_rate_hz   = 32'h001312D0;
    logic [31:0] sync_rate_hz = 32'h00098968;
    logic        sync_filt_on = 1'b0;
    logic        slow         = 1'b0;
    logic [31:0] meas_flt [4] = '{32'h3F800000, 32'h40000000, 32'h40400000, 32'h40800000};
    logic [31:0] meas_fix [4] = '{32'h01000000, 32'h00800000, 32'h02000000, 32'h0};
    logic [31:0] reg_rdata, udp_dst_ip, rv;
    logic [15:0] udp_dst_port;
    logic [10:0] udp_len;
    logic [7:0]  udp_data;
    logic        udp_valid, udp_ready, udp_last;
    int          err_total = 0;
    int          checked   = 0;
    // channel, format, options, size, length, first word
    rus_row_s    rows [4] = '{
        '{2'h0, 1'b0, 2'h2, 2'h3, 11'h084, 32'h3F800000},
        '{2'h1, 1'b1, 2'h2, 2'h2, 11'h104, 32'h00007333},
        '{2'h2, 1'b1, 2'h1, 2'h1, 11'h204, 32'h00007FFF},
        '{2'h3, 1'b0, 2'h1, 2'h0, 11'h404, 32'h3F800000}};

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    rus_streamer u_rus_streamer (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_src_ip(cmd_src_ip), .tc_rate_hz(tc_rate_hz),
        .sync_rate_hz(sync_rate_hz), .sync_filt_on(sync_filt_on), .meas_flt(meas_flt), .meas_fix(meas_fix),
        .udp_valid(udp_valid), .udp_ready(udp_ready), .udp_data(udp_data), .udp_last(udp_last),
        .udp_dst_port(udp_dst_port), .udp_dst_ip(udp_dst_ip), .udp_len(udp_len));
    rus_rx_model u_rus_rx_model (.ref_clk(ref_clk), .rstn(rstn), .slow(slow), .udp_valid(udp_valid),
        .udp_data(udp_data), .udp_last(udp_last), .udp_ready(udp_ready));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task conclude;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    function automatic logic [31:0] rxb(input int i);
        return {24'h0, u_rus_rx_model.q[i]};
    endfunction : rxb

    // start, note where the new traffic begins
    task start(output int b, output int s);
        b = u_rus_rx_model.len_q.size();
        s = u_rus_rx_model.q.size();
        wr(`RUS_A_CTRL, 32'h1);
        @(posedge ref_clk);
        #1;
    endtask : start

    task wait_pkt(input int n);
        int i;
        for (i = 0; i < 20000 && u_rus_rx_model.len_q.size() < n; i++)
            @(posedge ref_clk);
        if (u_rus_rx_model.len_q.size() < n)
        begin
            err_total++;
            conclude();
        end
    endtask : wait_pkt

    task stop;
        int i;
        wr(`RUS_A_CTRL, 32'h0);
        rd(`RUS_A_STATUS, rv);
        for (i = 0; i < 3000 && rv[1:0] !== 2'h0; i++)
            rd(`RUS_A_STATUS, rv);
        chk({30'h0, rv[1:0]}, 32'h0);
    endtask : stop

    // main sequence
    initial
    begin
        int r, k, base, qb, nb;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        for (r = 0; r < 4; r++)
        begin
            wr(`RUS_A_CHAN, {30'h0, rows[r].ch});
            wr(`RUS_A_FMT, {31'h0, rows[r].fmt});
            wr(`RUS_A_OPT, {30'h0, rows[r].opt});
            wr(`RUS_A_PSIZE, {30'h0, rows[r].ps});
            start(base, qb);
            chk({21'h0, udp_len}, {21'h0, rows[r].len});
            chk(udp_dst_ip, cmd_src_ip);
            chk({16'h0, udp_dst_port}, 32'h749);
            wr(`RUS_A_PSIZE, 32'h0);
            @(posedge ref_clk);
            chk({21'h0, udp_len}, {21'h0, rows[r].len});
            rd(`RUS_A_CTRL, rv);
            chk({31'h0, rv[0]}, 32'h1);
            wait_pkt(base + 1);
            chk(u_rus_rx_model.len_q[base], {21'h0, rows[r].len});
            chk(rxb(qb), {24'h0, rows[r].ch, rows[r].fmt, rows[r].opt, rows[r].ps, 1'b0});
            chk((rxb(qb + 1) << 16) | (rxb(qb + 2) << 8) | rxb(qb + 3), 32'h0);
            nb = rows[r].fmt ? 2 : 4;
            for (k = 0; k < nb; k++)
                chk(rxb(qb + 4 + k), {24'h0, rows[r].w[8 * (rows[r].opt[0] ? k : nb - 1 - k) +: 8]});
            stop();
        end
        // refused values keep the old setting
        wr(`RUS_A_RATE, 32'h4);
        wr(`RUS_A_RATE, 32'h15);
        rd(`RUS_A_RATE, rv);
        chk(rv, 32'h4);
        wr(`RUS_A_PORT, 32'h3039);
        wr(`RUS_A_PORT, 32'h3FF);
        wr(`RUS_A_PORT, 32'h10000);
        rd(`RUS_A_PORT, rv);
        chk(rv, 32'h3039);
        rd(8'h30, rv);
        chk(rv, 32'h0);
        // max rate capped, then limited by sync filter
        @(posedge ref_clk);
        tc_rate_hz <= 32'h002DC6C0;
        rd(`RUS_A_MAXRATE, rv);
        chk(rv, 32'h001312D0);
        @(posedge ref_clk);
        sync_filt_on <= 1'b1;
        rd(`RUS_A_MAXRATE, rv);
        chk(rv, 32'h00098968);
        // slow receiver, two packets, sequence counts up
        wr(`RUS_A_RATE, 32'h2);
        wr(`RUS_A_CHAN, 32'h0);
        wr(`RUS_A_FMT, 32'h0);
        wr(`RUS_A_OPT, 32'h2);
        wr(`RUS_A_PSIZE, 32'h3);
        slow <= 1'b1;
        start(base, qb);
        wait_pkt(base + 2);
        chk((rxb(qb + 134) << 8) | rxb(qb + 135), 32'h1);
        chk(u_rus_rx_model.len_q[base + 1], 32'h84);
        chk(rxb(qb + 133), 32'h2);
        // reset in mid-run restores defaults
        rstn <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b1;
        rd(`RUS_A_PORT, rv);
        chk(rv, 32'h749);
        rd(`RUS_A_OPT, rv);
        chk(rv, 32'h2);
        chk({21'h0, udp_len}, 32'h404);
        chk(udp_dst_ip, 32'h0);
        chk({16'h0, udp_dst_port}, 32'h749);
        chk({31'h0, udp_valid}, 32'h0);
        rd(`RUS_A_RATE, rv);
        chk(rv, 32'h0);
        conclude();
    end
endmodule : realtime_udp_sample_streamer_test
